/* File: sfl_cfg.svh */
`ifndef SFL_CFG_SVH
`define SFL_CFG_SVH

// ============================================================
// reset values
`define SFL_FLAG_RESET   8'h80
`define SFL_MASK_RESET   8'hff
`define SFL_DT_RESET     8'hff
`define SFL_CAL_RESET    8'h00

// ============================================================
// timing counts
`define SFL_TB_DIV       4'h3
`define SFL_CAL_LIMIT    13'h1000

// ============================================================
// general status flag positions
`define SFL_BIT_TEMP     0
`define SFL_BIT_DESATURATION_DETECT    1
`define SFL_BIT_SUPPLY   2
`define SFL_BIT_OVC      3
`define SFL_BIT_PHASE    4
`define SFL_BIT_FRAME    5
`define SFL_BIT_WRITE    6
`define SFL_BIT_RESET    7

// ============================================================
// mode command field positions
`define SFL_MODE_LOCK    0
`define SFL_MODE_SIMUL   1
`define SFL_MODE_DESATURATION_DETECT   3

// ============================================================
// command opcodes (upper bits of the command byte)
`define SFL_OP_NULL      3'h0
`define SFL_OP_MODE      3'h2
`define SFL_OP_DEAD      3'h4
`define SFL_OP_IEN0      4'h2
`define SFL_OP_IEN1      4'h3
`define SFL_OP_CLR0      4'h6
`define SFL_OP_CLR1      4'h7

`endif

/* File: sfl_pkg.sv */
`include "sfl_cfg.svh"

package sfl_pkg;

  // ============================================================
  // command classes
  typedef enum logic [2:0] {
    CMD_NULL  = 3'b000,
    CMD_IEN0  = 3'b001,
    CMD_IEN1  = 3'b010,
    CMD_MODE  = 3'b011,
    CMD_CLR0  = 3'b100,
    CMD_CLR1  = 3'b101,
    CMD_DEAD  = 3'b110,
    CMD_BAD   = 3'b111
  } sfl_cmd_type;

  // ============================================================
  // deadtime calibration states
  typedef enum logic [1:0] {
    CAL_IDLE  = 2'b00,
    CAL_ARMED = 2'b01,
    CAL_MEAS  = 2'b10
  } sfl_cal_state_type;

  // ============================================================
  // grouped signals
  typedef struct packed {
    logic [2:0] over_temperature_detect;
    logic [2:0] desaturation_detect;
    logic       supply_low;
    logic       over_current;
  } sfl_fault_type;

  typedef struct packed {
    logic sclk;
    logic cs_n;
    logic si;
  } sfl_spi_type;

  typedef struct packed {
    logic lock;
    logic simultaneous_on_mode;
    logic desaturation_detect_mode;
  } sfl_mode_type;

  // classify a received command byte, don't-care bits ignored
  function automatic sfl_cmd_type sfl_decode(input logic [7:0] b);
    sfl_cmd_type c;
    c = CMD_BAD;
    if (b[7:5] == `SFL_OP_NULL) c = CMD_NULL;
    else if (b[7:4] == `SFL_OP_IEN0) c = CMD_IEN0;
    else if (b[7:4] == `SFL_OP_IEN1) c = CMD_IEN1;
    else if (b[7:5] == `SFL_OP_MODE) c = CMD_MODE;
    else if (b[7:4] == `SFL_OP_CLR0) c = CMD_CLR0;
    else if (b[7:4] == `SFL_OP_CLR1) c = CMD_CLR1;
    else if (b[7:5] == `SFL_OP_DEAD) c = CMD_DEAD;
    return c;
  endfunction : sfl_decode

endpackage : sfl_pkg

/* File: sfl_sync.sv */
`timescale 1ns/100ps
`default_nettype none

module sfl_sync #(
  parameter int             W       = 1,
  parameter logic [W-1:0]   RST_VAL = '0
) (
  input  wire logic         i_mclk,
  input  wire logic         i_reset,
  input  wire logic [W-1:0] i_async,
  output logic      [W-1:0] o_sync
);

  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  // ============================================================
  // two-stage synchroniser, first stage feeds only the second
  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      meta_q <= RST_VAL;
      sync_q <= RST_VAL;
    end else begin
      meta_q <= i_async;
      sync_q <= meta_q;
    end
  end

  assign o_sync = sync_q;

endmodule : sfl_sync

`default_nettype wire

/* File: sfl_phase_chk.sv */
`timescale 1ns/100ps
`default_nettype none

module sfl_phase_chk (
  input  wire logic       i_mclk,
  input  wire logic       i_reset,
  input  wire logic       i_tb_tick,
  input  wire logic [7:0] i_deadtime,
  input  wire logic       i_hs_on,
  input  wire logic       i_ls_on,
  input  wire logic       i_phase_node_sense,
  input  wire logic       i_blank,
  input  wire logic       i_simul_on,
  output logic            o_hs_err,
  output logic            o_ls_err,
  output logic            o_xor_err
);

  logic [7:0] cnt_q, cnt_d;
  logic [1:0] drv_q, drv_d;
  logic       hs_err_q, hs_err_d;
  logic       ls_err_q, ls_err_d;
  logic       xor_err_q, xor_err_d;
  logic       one_on;
  logic       expired;

  // ============================================================
  // deadtime timer since drive state changed, and error terms
  always_comb begin
    drv_d   = {i_hs_on, i_ls_on};
    one_on  = i_hs_on ^ i_ls_on;
    cnt_d   = cnt_q;
    if (drv_d != drv_q) cnt_d = 8'h00;
    else if (i_tb_tick && cnt_q != 8'hff) cnt_d = cnt_q + 8'h01;
    expired = one_on && (drv_d == drv_q) && (cnt_q >= i_deadtime);
    // node still low after high side on, or high after low side on
    hs_err_d  = expired && i_hs_on && !i_phase_node_sense;
    ls_err_d  = expired && i_ls_on && i_phase_node_sense;
    // comparator against drive state, blanked and off in full-on
    xor_err_d = one_on && !i_blank && !i_simul_on &&
                (i_phase_node_sense != i_hs_on);
  end

  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      cnt_q     <= 8'h00;
      drv_q     <= 2'b00;
      hs_err_q  <= 1'b0;
      ls_err_q  <= 1'b0;
      xor_err_q <= 1'b0;
    end else begin
      cnt_q     <= cnt_d;
      drv_q     <= drv_d;
      hs_err_q  <= hs_err_d;
      ls_err_q  <= ls_err_d;
      xor_err_q <= xor_err_d;
    end
  end

  assign o_hs_err  = hs_err_q;
  assign o_ls_err  = ls_err_q;
  assign o_xor_err = xor_err_q;

endmodule : sfl_phase_chk

`default_nettype wire

/* File: sfl_status_bank.sv */
// What this block does
// - null command with low bits 00 selects general status; others also return it.
// - every general status flag stays set after its cause goes away.
// - a flag clears only by matching clear bit, and not while cause persists.
// - clear commands share bit layout with first and second mask commands.
// - bit 0 is OR of the three over-temperature detectors.
// - bit 1 is OR of desaturation detectors and high- and low-side phase errors.
// - phase error when node disagrees with switched-on side one deadtime later.
// - bit 2 latches low gate supply voltage.
// - bit 3 latches over-current comparator assertion.
// - bit 4 latches node-versus-drive mismatch, blanked during desaturation_detect blanking and off in full-on mode.
// - bit 5 latches non-multiple-of-eight frames and clock during calibration.
// - bit 6 latches writes after lock and undefined command codes.
// - bit 7 is set on leaving reset; other flags reset to zero.
// - a flag drives the interrupt output only when its mask bit is set.
// - mode status read is side-effect free; bits 7,2 zero, bit 1 full-on.
// - mode bit 0 shows lock; locked writes are ignored and flag write error.
// - mode bit 3 set once a deadtime command completes, zero or overflow too.
// - mode bit 4 flags calibration overflow.
// - mode bit 5 set when zero deadtime was commanded.
// - mode bit 6 mirrors desaturation shutdown mode.
// - mask read returns second mask high nibble, first mask low; resets ones.
// - deadtime read returns stored eight-bit calibration without side effects.
// - deadtime readback is zero before calibration while applied value is max.
// - mask bits map to flags 0 to 7 in order.
// - applied deadtime resets to 255 time-base cycles until replaced.
`timescale 1ns/100ps
`default_nettype none

module sfl_status_bank
  import sfl_pkg::*;
#(
  parameter logic [3:0] TB_DIV = `SFL_TB_DIV
) (
  input  wire logic          i_mclk,
  input  wire logic          i_reset,
  input  wire logic          i_sclk,
  input  wire logic          i_cs_n,
  input  wire logic          i_si,
  output logic               o_so,
  output logic               o_so_oe,
  output logic               o_irq,
  input  wire sfl_fault_type i_fault,
  input  wire logic [2:0]    i_hs_on,
  input  wire logic [2:0]    i_ls_on,
  input  wire logic [2:0]    i_blank,
  input  wire logic [2:0]    i_phase_node_sense,
  output logic [7:0]         o_deadtime,
  output logic               o_simultaneous_on_mode,
  output logic               o_desaturation_detect_mode
);

  // ============================================================
  // declarations
  sfl_spi_type       spi_s;
  sfl_fault_type     flt_s;
  logic [2:0]        node_s;
  logic [2:0]        hs_err, ls_err, xor_err;
  logic [3:0]        tb_cnt_q, tb_cnt_d;
  logic              tb_tick_q, tb_tick_d;
  logic              sclk_p_q, cs_p_q;
  logic              sclk_rise, sclk_fall, cs_fall, cs_rise;
  logic              frame_q, frame_d;
  logic [7:0]        rx_q, rx_d, tx_q, tx_d;
  logic [2:0]        bits_q, bits_d;
  logic              seen_q, seen_d;
  logic              so_q, so_d, oe_q, oe_d;
  logic              exec, fe_spi, fe_cal, we;
  sfl_cmd_type       cmd;
  logic [7:0]        status_sel;
  sfl_mode_type      mode_q, mode_d;
  logic [7:0]        mask_q, mask_d;
  logic [7:0]        dt_q, dt_d, cal_q, cal_d;
  logic              done_q, done_d, ovf_q, ovf_d, zero_q, zero_d;
  logic [1:0]        sel_q, sel_d;
  sfl_cal_state_type st_q, st_d;
  logic [12:0]       cnt_q, cnt_d;
  logic [7:0]        cond_vec, clr_vec;
  logic [7:0]        flags_q, flags_d;
  logic              irq_q, irq_d;

  // ============================================================
  // pin synchronisers
  sfl_sync #(.W(3), .RST_VAL(3'b010)) u_spi_sync (
    .i_mclk  (i_mclk),
    .i_reset (i_reset),
    .i_async ({i_sclk, i_cs_n, i_si}),
    .o_sync  (spi_s)
  );

  sfl_sync #(.W(11), .RST_VAL(11'h000)) u_flt_sync (
    .i_mclk  (i_mclk),
    .i_reset (i_reset),
    .i_async ({i_fault, i_phase_node_sense}),
    .o_sync  ({flt_s, node_s})
  );

  // ============================================================
  // per-phase error checkers
  for (genvar p = 0; p < 3; p++) begin : g_phase
    sfl_phase_chk u_chk (
      .i_mclk             (i_mclk),
      .i_reset            (i_reset),
      .i_tb_tick          (tb_tick_q),
      .i_deadtime         (dt_q),
      .i_hs_on            (i_hs_on[p]),
      .i_ls_on            (i_ls_on[p]),
      .i_phase_node_sense (node_s[p]),
      .i_blank            (i_blank[p]),
      .i_simul_on         (mode_q.simultaneous_on_mode),
      .o_hs_err           (hs_err[p]),
      .o_ls_err           (ls_err[p]),
      .o_xor_err          (xor_err[p])
    );
  end

  // ============================================================
  // internal time-base enable
  always_comb begin
    tb_tick_d = (tb_cnt_q == TB_DIV - 4'h1);
    tb_cnt_d  = tb_tick_d ? 4'h0 : tb_cnt_q + 4'h1;
  end

  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      tb_cnt_q  <= 4'h0;
      tb_tick_q <= 1'b0;
    end else begin
      tb_cnt_q  <= tb_cnt_d;
      tb_tick_q <= tb_tick_d;
    end
  end

  // ============================================================
  // status word selected for the next frame
  always_comb begin
    unique case (sel_q)
      2'b00: status_sel = flags_q;
      2'b01: status_sel = {1'b0, mode_q.desaturation_detect_mode, zero_q, ovf_q,
                           done_q, 1'b0, mode_q.simultaneous_on_mode,
                           mode_q.lock};
      2'b10: status_sel = mask_q;
      2'b11: status_sel = cal_q;
    endcase
  end

  // ============================================================
  // spi frame: sample on sclk rise, shift out on sclk fall
  assign sclk_rise = spi_s.sclk && !sclk_p_q;
  assign sclk_fall = !spi_s.sclk && sclk_p_q;
  assign cs_fall   = !spi_s.cs_n && cs_p_q;
  assign cs_rise   = spi_s.cs_n && !cs_p_q;
  assign cmd       = sfl_decode(rx_q);

  always_comb begin
    frame_d = frame_q;
    rx_d    = rx_q;
    tx_d    = tx_q;
    bits_d  = bits_q;
    seen_d  = seen_q;
    so_d    = so_q;
    oe_d    = oe_q;
    exec    = 1'b0;
    fe_spi  = 1'b0;
    if (cs_fall && st_q == CAL_IDLE) begin
      frame_d = 1'b1;
      tx_d    = status_sel;
      so_d    = status_sel[7];
      oe_d    = 1'b1;
      bits_d  = 3'h0;
      seen_d  = 1'b0;
    end else if (frame_q && cs_rise) begin
      frame_d = 1'b0;
      oe_d    = 1'b0;
      // whole bytes only, at least one
      if (bits_q == 3'h0 && seen_q) exec = 1'b1;
      else fe_spi = 1'b1;
    end else if (frame_q) begin
      if (sclk_rise) begin
        rx_d   = {rx_q[6:0], spi_s.si};
        bits_d = bits_q + 3'h1;
        seen_d = 1'b1;
      end
      if (sclk_fall) begin
        so_d = tx_q[6];
        tx_d = {tx_q[6:0], 1'b0};
      end
    end
  end

  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      sclk_p_q <= 1'b0;
      cs_p_q   <= 1'b1;
      frame_q  <= 1'b0;
      rx_q     <= 8'h00;
      tx_q     <= 8'h00;
      bits_q   <= 3'h0;
      seen_q   <= 1'b0;
      so_q     <= 1'b0;
      oe_q     <= 1'b0;
    end else begin
      sclk_p_q <= spi_s.sclk;
      cs_p_q   <= spi_s.cs_n;
      frame_q  <= frame_d;
      rx_q     <= rx_d;
      tx_q     <= tx_d;
      bits_q   <= bits_d;
      seen_q   <= seen_d;
      so_q     <= so_d;
      oe_q     <= oe_d;
    end
  end

  // ============================================================
  // command execution and deadtime calibration
  always_comb begin
    mode_d  = mode_q;
    mask_d  = mask_q;
    dt_d    = dt_q;
    cal_d   = cal_q;
    done_d  = done_q;
    ovf_d   = ovf_q;
    zero_d  = zero_q;
    sel_d   = sel_q;
    st_d    = st_q;
    cnt_d   = cnt_q;
    we      = 1'b0;
    fe_cal  = 1'b0;
    clr_vec = 8'h00;
    if (exec) begin
      // null picks a register, any other command returns general
      sel_d = (cmd == CMD_NULL) ? rx_q[1:0] : 2'b00;
      if (cmd == CMD_BAD) begin
        we = 1'b1;
      end else if (mode_q.lock && cmd != CMD_NULL) begin
        we = 1'b1;
      end else begin
        unique case (cmd)
          CMD_NULL:  ;
          CMD_IEN0:  mask_d[3:0] = rx_q[3:0];
          CMD_IEN1:  mask_d[7:4] = rx_q[3:0];
          CMD_MODE: begin
            mode_d.lock = mode_q.lock | rx_q[`SFL_MODE_LOCK];
            mode_d.simultaneous_on_mode = rx_q[`SFL_MODE_SIMUL];
            mode_d.desaturation_detect_mode = rx_q[`SFL_MODE_DESATURATION_DETECT];
          end
          CMD_CLR0:  clr_vec[3:0] = rx_q[3:0];
          CMD_CLR1:  clr_vec[7:4] = rx_q[3:0];
          CMD_DEAD: begin
            if (rx_q[0]) begin
              st_d = CAL_ARMED;
            end else begin
              dt_d   = 8'h00;
              cal_d  = 8'h00;
              zero_d = 1'b1;
              done_d = 1'b1;
              ovf_d  = 1'b0;
            end
          end
          CMD_BAD:   we = 1'b1;
        endcase
      end
    end
    unique case (st_q)
      CAL_IDLE: ;
      CAL_ARMED: begin
        if (cs_fall) begin
          st_d  = CAL_MEAS;
          cnt_d = 13'h0000;
        end
      end
      CAL_MEAS: begin
        if (tb_tick_q && cnt_q != `SFL_CAL_LIMIT) cnt_d = cnt_q + 13'h0001;
        if (sclk_rise || sclk_fall) fe_cal = 1'b1;
        if (cs_rise) begin
          st_d   = CAL_IDLE;
          done_d = 1'b1;
          zero_d = 1'b0;
          if (cnt_q == `SFL_CAL_LIMIT) begin
            ovf_d = 1'b1;
            dt_d  = 8'hff;
            cal_d = 8'hff;
          end else begin
            ovf_d = 1'b0;
            dt_d  = cnt_q[11:4];
            cal_d = cnt_q[11:4];
          end
        end
      end
      default: st_d = CAL_IDLE;
    endcase
  end

  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      mode_q <= '0;
      mask_q <= `SFL_MASK_RESET;
      dt_q   <= `SFL_DT_RESET;
      cal_q  <= `SFL_CAL_RESET;
      done_q <= 1'b0;
      ovf_q  <= 1'b0;
      zero_q <= 1'b0;
      sel_q  <= 2'b00;
      st_q   <= CAL_IDLE;
      cnt_q  <= 13'h0000;
    end else begin
      mode_q <= mode_d;
      mask_q <= mask_d;
      dt_q   <= dt_d;
      cal_q  <= cal_d;
      done_q <= done_d;
      ovf_q  <= ovf_d;
      zero_q <= zero_d;
      sel_q  <= sel_d;
      st_q   <= st_d;
      cnt_q  <= cnt_d;
    end
  end

  // ============================================================
  // latched fault flags and interrupt
  always_comb begin
    cond_vec = 8'h00;
    cond_vec[`SFL_BIT_TEMP]   = |flt_s.over_temperature_detect;
    cond_vec[`SFL_BIT_DESATURATION_DETECT]  = |flt_s.desaturation_detect |
                                |hs_err | |ls_err;
    cond_vec[`SFL_BIT_SUPPLY] = flt_s.supply_low;
    cond_vec[`SFL_BIT_OVC]    = flt_s.over_current;
    cond_vec[`SFL_BIT_PHASE]  = |xor_err;
    cond_vec[`SFL_BIT_FRAME]  = fe_spi | fe_cal;
    cond_vec[`SFL_BIT_WRITE]  = we;
    // live cause beats clear; otherwise hold until cleared
    flags_d = cond_vec | (flags_q & ~clr_vec);
    irq_d   = |(flags_q & mask_q);
  end

  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      flags_q <= `SFL_FLAG_RESET;
      irq_q   <= 1'b0;
    end else begin
      flags_q <= flags_d;
      irq_q   <= irq_d;
    end
  end

  assign o_so                   = so_q;
  assign o_so_oe                = oe_q;
  assign o_irq                  = irq_q;
  assign o_deadtime             = dt_q;
  assign o_simultaneous_on_mode = mode_q.simultaneous_on_mode;
  assign o_desaturation_detect_mode           = mode_q.desaturation_detect_mode;

  // ============================================================
  // assertions
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_reset);

  chk_flag_hold: assert property (
    1'b1 |=> ((flags_q & $past(flags_q & ~clr_vec))
              == $past(flags_q & ~clr_vec)))
    else $error("latched flag dropped without clear");

  chk_clear_only_cmd: assert property (
    !$stable(flags_q) |->
      (($past(flags_q) & ~flags_q & ~$past(clr_vec)) == 8'h00))
    else $error("flag fell without a clear command");

  chk_cause_wins: assert property (
    (cond_vec & clr_vec) != 8'h00 |=>
      ((flags_q & $past(cond_vec & clr_vec)) == $past(cond_vec & clr_vec)))
    else $error("flag cleared while cause present");

  chk_irq_masked: assert property (
    ((flags_q & mask_q) == 8'h00) [*2] |-> !o_irq)
    else $error("interrupt without unmasked flag");

  chk_locked_write: assert property (
    exec && mode_q.lock && (cmd == CMD_IEN0 || cmd == CMD_MODE) |=>
      $stable(mask_q) && $stable(mode_q) ##1 flags_q[`SFL_BIT_WRITE])
    else $error("locked write not refused");

  chk_frame_error: assert property (
    frame_q && cs_rise && bits_q != 3'h0 |-> ##2 flags_q[`SFL_BIT_FRAME])
    else $error("partial byte frame not flagged");

  chk_zero_deadtime: assert property (
    exec && cmd == CMD_DEAD && !rx_q[0] && !mode_q.lock |=>
      zero_q && done_q && dt_q == 8'h00 && cal_q == 8'h00)
    else $error("zero deadtime command not applied");

  chk_null_quiet: assert property (
    exec && cmd == CMD_NULL |=> $stable(mask_q) && $stable(mode_q) &&
      $stable(dt_q) && sel_q == $past(rx_q[1:0]))
    else $error("status read changed state");

  chk_general_after: assert property (
    exec && cmd != CMD_NULL |=> sel_q == 2'b00)
    else $error("general status not selected");

  chk_uncal_readback: assert property (
    !done_q |-> cal_q == 8'h00 && (zero_q || dt_q == 8'hff))
    else $error("deadtime readback before calibration");

  cov_calibration: cover property (st_q == CAL_MEAS && cs_rise);
  cov_irq_rise: cover property ($rose(o_irq));
  cov_clear: cover property (clr_vec != 8'h00 ##1 flags_q == 8'h00);
  cov_locked: cover property (exec && mode_q.lock && we);

endmodule : sfl_status_bank

`default_nettype wire

/* File: sfl_host_model.sv */
`timescale 1ns/100ps
`default_nettype none

// ============================================================
// host side spi master, mode 0
module sfl_host_model (
  input  wire logic i_mclk,
  input  wire logic i_so,
  output logic      o_sclk,
  output logic      o_cs_n,
  output logic      o_si
);
  // clock idles low, chip select released
  initial begin
    o_sclk = 1'b0;
    o_cs_n = 1'b1;
    o_si   = 1'b0;
  end

  // n clocks msb first, reply taken before each rise
  task automatic run(input int n, input logic [7:0] c,
                     output logic [7:0] r);
    r = 8'h00;
    @(posedge i_mclk) #2 o_cs_n = 1'b0;
    for (int i = 7; i > 7 - n; i--) begin
      o_si = c[i];
      repeat (5) @(posedge i_mclk);
      #2 r[i] = i_so;
      o_sclk = 1'b1;
      repeat (5) @(posedge i_mclk);
      #2 o_sclk = 1'b0;
    end
    repeat (5) @(posedge i_mclk);
    #2 o_cs_n = 1'b1;
    o_si = ~o_si; // released line shows no stale level
    repeat (6) @(posedge i_mclk);
  endtask : run

  // calibration pulse of n mclk, no serial clock
  task automatic cal(input int n);
    @(posedge i_mclk) #2 o_cs_n = 1'b0;
    repeat (n) @(posedge i_mclk);
    #2 o_cs_n = 1'b1;
    repeat (6) @(posedge i_mclk);
  endtask : cal
endmodule : sfl_host_model

`default_nettype wire

/* File: test_spi_status_fault_latch_readout.sv */
`timescale 1ns/100ps
`default_nettype none

// ============================================================
// bench
module test_spi_status_fault_latch_readout;
  import sfl_pkg::*;
  logic          mclk, rst, sclk, cs_n, si, so, so_oe, irq, fon, dmd;
  sfl_fault_type fault;
  logic [2:0]    hs_on, ls_on, blank, node;
  logic [7:0]    dt, v, m;
  int            err_count, checks_done, cyc;

  sfl_status_bank #(.TB_DIV(4'h1)) dut (.i_mclk(mclk), .i_reset(rst),
    .i_sclk(sclk), .i_cs_n(cs_n), .i_si(si), .o_so(so),
    .o_so_oe(so_oe), .o_irq(irq), .i_fault(fault), .i_hs_on(hs_on),
    .i_ls_on(ls_on), .i_blank(blank), .i_phase_node_sense(node),
    .o_deadtime(dt), .o_simultaneous_on_mode(fon), .o_desaturation_detect_mode(dmd));
  sfl_host_model host (.i_mclk(mclk), .i_so(so), .o_sclk(sclk),
    .o_cs_n(cs_n), .o_si(si));

  // 50 mhz clock
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  task automatic check(input logic [7:0] s, input logic [7:0] e);
    checks_done++;
    if (s !== e) begin
      err_count++;
      $display("mismatch at %0t seen %h expected %h", $time, s, e);
    end
  endtask : check

  task automatic give_verdict;
    $display("checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : give_verdict

  task automatic cmd(input logic [7:0] c);
    logic [7:0] r;
    host.run(8, c, r);
  endtask : cmd

  // status read, don't-care bits random
  task automatic rd(input logic [1:0] s, input logic [7:0] e);
    logic [7:0] x;
    cmd({3'h0, 3'($urandom), s});
    host.run(8, 8'h00, x);
    check(x, e);
  endtask : rd

  function automatic logic [7:0] fexp(input sfl_fault_type f);
    return {4'h0, f.over_current, f.supply_low,
            |f.desaturation_detect, |f.over_temperature_detect};
  endfunction : fexp

  // hang guard
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 40000) begin
      err_count++;
      give_verdict();
    end
  end

  initial begin
    {fault, hs_on, ls_on, blank, node} = '0;
    err_count = 0;
    checks_done = 0;
    cyc = 0;
    rst = 1'b1;
    void'($urandom(76138));
    repeat (12) @(posedge mclk);
    #2 rst = 1'b0;
    repeat (4) @(posedge mclk);
    check(dt, 8'hff);
    check({7'h0, irq}, 8'h01);
    check({7'h0, so_oe}, 8'h00);
    rd(2'h0, 8'h80);
    rd(2'h1, 8'h00);
    rd(2'h2, 8'hff);
    rd(2'h3, 8'h00);
    // output enable stands through a frame
    fork
      cmd(8'h00);
      begin
        repeat (20) @(posedge mclk);
        #2 check({7'h0, so_oe}, 8'h01);
      end
    join
    cmd(8'h78);
    rd(2'h0, 8'h00);
    // random faults, supply low held through the clear
    repeat (6) begin
      m = 8'($urandom) | 8'h02;
      @(posedge mclk) #2 fault = m;
      repeat (6) @(posedge mclk);
      #2 fault = m & 8'h02;
      rd(2'h0, fexp(m));
      cmd(8'h6f);
      rd(2'h0, fexp(m & 8'h02));
      @(posedge mclk) #2 fault = '0;
      cmd(8'h6f);
    end
    // mask readback and interrupt gating
    m = 8'($urandom);
    cmd({4'h2, m[3:0]});
    cmd({4'h3, m[7:4]});
    rd(2'h2, m);
    @(posedge mclk) #2 fault = 8'h01;
    repeat (6) @(posedge mclk);
    #2 fault = '0;
    repeat (3) @(posedge mclk);
    check({7'h0, irq}, {7'h0, m[3]});
    cmd(8'h68);
    host.run(4, 8'h00, v);
    rd(2'h0, 8'h20);
    cmd(8'hb0);
    rd(2'h0, 8'h60);
    cmd(8'h76);
    // high side on, node stays low past deadtime
    @(posedge mclk) #2 hs_on = 3'h1;
    repeat (400) @(posedge mclk);
    #2 hs_on = '0;
    rd(2'h0, 8'h12);
    cmd(8'h62);
    cmd(8'h71);
    // low side on, node high past deadtime, comparator blanked
    @(posedge mclk) #2 {ls_on, node, blank} = {3{3'h2}};
    repeat (400) @(posedge mclk);
    #2 {ls_on, node, blank} = '0;
    rd(2'h0, 8'h02);
    cmd(8'h62);
    cmd(8'h80);
    rd(2'h1, 8'h28);
    rd(2'h3, 8'h00);
    check(dt, 8'h00);
    cmd(8'h81);
    host.cal(328);
    rd(2'h3, 8'h14);
    check(dt, 8'h14);
    rd(2'h1, 8'h08);
    // serial clock during a calibration pulse
    cmd(8'h81);
    host.run(8, 8'h00, v);
    check(dt, 8'h05);
    rd(2'h0, 8'h20);
    cmd(8'h72);
    cmd(8'h81);
    host.cal(4200);
    rd(2'h1, 8'h18);
    rd(2'h3, 8'hff);
    cmd(8'h4a);
    rd(2'h1, 8'h5a);
    check({6'h0, fon, dmd}, 8'h03);
    cmd(8'h4b);
    cmd(8'h2a);
    rd(2'h2, m);
    rd(2'h0, 8'h40);
    rd(2'h1, 8'h5b);
    give_verdict();
  end
endmodule : test_spi_status_fault_latch_readout

`default_nettype wire
